// [src/dps_device.sv]
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// (R1) parallel direction one floats, zero drives
// (R2) latch register reads back latch value
// (R3) mode bit four enables slave port
// (R4) three control pins, individually directed
// (R5) control direction one input, zero drives
// (R6) control latch reads back latch value
// (R7) analog-selected control pin reads zero
// (R8) direction bits act in analog mode
// (R9) software keeps analog pins as inputs
// (R10) input-full shows unread host byte
// (R11) output-full until host reads byte
// (R12) host write while full sets overflow
// (R13) upper four bits control slave port
// (R14) pins 0,1,2 are rd, wr, cs
// (R15) software sets control pins input first
// (R16) write captured on first cs+wr low
// (R17) read presented on first cs+rd low
// (R18) host accesses independent of processor
// (R19) synchronise strobes, act on falling edge
// (R20) processor and host accesses move flags
module dps_device (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // processor register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // pins
  dps_if.device           pins
);
  typedef struct packed {
    logic [7:0] lat;     // parallel output latch, also slave byte latch
    logic [7:0] dir;
    logic [7:0] in_byte; // byte written by host
    logic [2:0] clat;
    logic [2:0] cdir;
    logic [2:0] ana;
    logic       input_full_flag;
    logic       output_full_flag;
    logic       input_overflow_flag;
    logic       mode;
    logic [1:0] wr_s;    // two-stage sync of cs+wr
    logic [1:0] rd_s;    // two-stage sync of cs+rd
    logic       wr_p;    // previous synced level for edge detect
    logic       rd_p;
    logic [7:0] rdata;
  } dps_dev_st_t;

  dps_dev_st_t st_q, st_d;
  logic        hw_acc, hr_acc, hw_ev, hr_ev, rd_now;

  // strobes taken from the control pin level when slave mode is on
  assign hw_acc = st_q.mode & ~pins.pc_in[2] & ~pins.pc_in[1]; // [R14] [R16]
  assign hr_acc = st_q.mode & ~pins.pc_in[2] & ~pins.pc_in[0]; // [R14] [R17]
  // edges only look at the second sync stage
  assign hw_ev  = st_q.wr_s[1] & ~st_q.wr_p; // [R19]
  assign hr_ev  = st_q.rd_s[1] & ~st_q.rd_p; // [R19]
  // host read drives the latch while the strobe pair is low; the latch
  // holds steady so no clock is needed for the data path
  assign rd_now = hr_acc; // [R18]

  // pin drivers
  always_comb begin
    if (st_q.mode) begin
      pins.pd_dev_o  = st_q.lat;                         // [R17]
      pins.pd_dev_oe = {8{rd_now}};
    end else begin
      pins.pd_dev_o  = st_q.lat;
      pins.pd_dev_oe = ~st_q.dir;                        // [R1]
    end
    pins.pc_dev_o  = st_q.clat;
    pins.pc_dev_oe = ~st_q.cdir;                         // [R4] [R5] [R8]
  end

  // next state: registers, flags and readback
  always_comb begin
    st_d = st_q;
    st_d.wr_s  = {st_q.wr_s[0], hw_acc};
    st_d.rd_s  = {st_q.rd_s[0], hr_acc};
    st_d.wr_p  = st_q.wr_s[1];
    st_d.rd_p  = st_q.rd_s[1];
    st_d.rdata = 8'h00;
    // processor reads; clears come first so host events below win
    if (i_rd) begin
      unique case (i_addr)
        dps_pkg::REG_PINS: begin
          st_d.rdata = st_q.mode ? st_q.in_byte : pins.pd_in;
          if (st_q.mode) st_d.input_full_flag = 1'b0;                // [R20] [R10]
        end
        dps_pkg::REG_LATCH:    st_d.rdata = st_q.lat;     // [R2]
        dps_pkg::REG_DIR:      st_d.rdata = st_q.dir;
        dps_pkg::REG_CTRL_DIR: st_d.rdata = {st_q.input_full_flag, st_q.output_full_flag, st_q.input_overflow_flag,
                                  st_q.mode, 1'b0, st_q.cdir}; // [R13]
        dps_pkg::REG_CPINS:    st_d.rdata = {5'h00,
                                  pins.pc_in & ~st_q.ana}; // [R7]
        dps_pkg::REG_CLATCH:   st_d.rdata = {5'h00, st_q.clat}; // [R6]
        dps_pkg::REG_ANALOG:   st_d.rdata = {5'h00, st_q.ana};
        default:               st_d.rdata = 8'h00;
      endcase
    end
    // processor writes
    if (i_wr) begin
      unique case (i_addr)
        dps_pkg::REG_PINS, dps_pkg::REG_LATCH: begin
          st_d.lat = i_wdata;
          if (st_q.mode) st_d.output_full_flag = 1'b1;                // [R20] [R11]
        end
        dps_pkg::REG_DIR:      st_d.dir = i_wdata;
        dps_pkg::REG_CTRL_DIR: begin
          st_d.cdir = i_wdata[2:0];
          st_d.mode = i_wdata[dps_pkg::BIT_MODE];        // [R3]
          // overflow is only cleared by software; a write of one keeps it
          if (!i_wdata[dps_pkg::BIT_INPUT_OVERFLOW_FLAG]) st_d.input_overflow_flag = 1'b0; // [R12]
        end
        dps_pkg::REG_CPINS, dps_pkg::REG_CLATCH: st_d.clat = i_wdata[2:0];
        dps_pkg::REG_ANALOG:   st_d.ana = i_wdata[2:0];
        default: ;
      endcase
    end
    // host write: byte is taken from the first synced sample; the host
    // holds data through the strobe so two cycles of sync are harmless
    if (hw_ev) begin
      st_d.in_byte = pins.pd_in;                         // [R16]
      if (st_q.input_full_flag) st_d.input_overflow_flag = 1'b1;                    // [R12]
      st_d.input_full_flag = 1'b1;                                   // [R10] [R20]
    end
    if (hr_ev) st_d.output_full_flag = 1'b0;                          // [R11]
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q      <= '0;
      st_q.dir  <= dps_pkg::RST_DIR;
      st_q.cdir <= dps_pkg::RST_CTRL_DIR;
      st_q.lat  <= dps_pkg::RST_LATCH;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
endmodule

// [src/dps_pkg.sv]
package dps_pkg;
  // register indices on the processor-side port
  localparam logic [2:0] REG_PINS     = 3'h0; // parallel pins / latch on write
  localparam logic [2:0] REG_LATCH    = 3'h1; // parallel output latch
  localparam logic [2:0] REG_DIR      = 3'h2; // parallel direction
  localparam logic [2:0] REG_CTRL_DIR = 3'h3; // control dir and slave status
  localparam logic [2:0] REG_CPINS    = 3'h4; // control pins / latch on write
  localparam logic [2:0] REG_CLATCH   = 3'h5; // control output latch
  localparam logic [2:0] REG_ANALOG   = 3'h6; // analog select for control pins
  // control_dir_and_slave_status fields
  localparam int BIT_IBF  = 7;
  localparam int BIT_OBF  = 6;
  localparam int BIT_INPUT_OVERFLOW_FLAG = 5;
  localparam int BIT_MODE = 4;
  // reset values
  localparam logic [7:0] RST_DIR      = 8'hFF;
  localparam logic [2:0] RST_CTRL_DIR = 3'h7;
  localparam logic [7:0] RST_LATCH    = 8'h00;
  // host side strobe hold, in reference clock cycles
  localparam int HOST_STROBE_CYC = 4;
endpackage

// [src/dps_if.sv]
`timescale 1ns/1ps
interface dps_if;
  logic [7:0] pd_dev_o; // parallel pins, device driver
  logic [7:0] pd_dev_oe;
  logic [7:0] pd_host_o; // parallel pins, host driver
  logic [7:0] pd_host_oe;
  logic [7:0] pd_in; // resolved level of the parallel pins
  logic [2:0] pc_dev_o; // control pins, device driver
  logic [2:0] pc_dev_oe;
  logic [2:0] pc_host_o; // control pins, host driver (rd_n, wr_n, cs_n)
  logic [2:0] pc_host_oe;
  logic [2:0] pc_in; // resolved level of the control pins
  modport device (output pd_dev_o, pd_dev_oe, pc_dev_o, pc_dev_oe,
                  input pd_in, pc_in);
  modport host (output pd_host_o, pd_host_oe, pc_host_o, pc_host_oe,
                input pd_in, pc_in);
endinterface

// [src/dps_host.sv]
`timescale 1ns/1ps
module dps_host #(
  parameter int STROBE_CYC = dps_pkg::HOST_STROBE_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // user requests
  input  wire logic       i_wr_req,
  input  wire logic       i_rd_req,
  input  wire logic [7:0] i_wdata,
  output logic            o_busy,
  output logic            o_rd_valid,
  output logic      [7:0] o_rdata,
  // pins
  dps_if.host             pins
);
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_WRITE = 2'b01,
    HS_READ  = 2'b10,
    HS_GAP   = 2'b11
  } dps_hst_state_t;

  typedef struct packed {
    dps_hst_state_t st;
    logic [7:0]     cnt;
    logic [7:0]     wdata;
    logic [7:0]     rdata;
    logic           rvalid;
  } dps_hst_st_t;

  dps_hst_st_t q, d;

  // sequencer: strobe held STROBE_CYC cycles so device sync sees it,
  // then a gap of the same length so the next access is a new edge
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    unique case (q.st)
      HS_IDLE: begin
        d.cnt = 8'(STROBE_CYC - 1);
        if (i_wr_req) begin
          d.st    = HS_WRITE;                            // [R16]
          d.wdata = i_wdata;
        end else if (i_rd_req) begin
          d.st = HS_READ;                                // [R17]
        end
      end
      HS_WRITE, HS_READ: begin
        if (q.cnt == 8'h00) begin
          if (q.st == HS_READ) begin
            d.rdata  = pins.pd_in;
            d.rvalid = 1'b1;
          end
          d.st  = HS_GAP;
          d.cnt = 8'(STROBE_CYC - 1);
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      HS_GAP: begin
        if (q.cnt == 8'h00) d.st = HS_IDLE;
        else d.cnt = q.cnt - 8'h01;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) q <= '0;
    else q <= d;
  end

  // control pins are always driven by the host: rd_n, wr_n, cs_n
  assign pins.pc_host_oe = 3'h7;
  assign pins.pc_host_o  = {~(q.st == HS_WRITE || q.st == HS_READ),
                            ~(q.st == HS_WRITE), ~(q.st == HS_READ)};
  assign pins.pd_host_o  = q.wdata;
  assign pins.pd_host_oe = {8{q.st == HS_WRITE}};
  assign o_busy          = (q.st != HS_IDLE);
  assign o_rd_valid      = q.rvalid;
  assign o_rdata         = q.rdata;
endmodule

// [sim/dps_assertions.sv]
`timescale 1ns/1ps
// watches the pins between the two ends
module dps_assertions (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic [7:0] pd_dev_oe,
  input wire logic [7:0] pd_host_oe,
  input wire logic [2:0] pc_dev_oe,
  input wire logic [2:0] pc_host_o,
  input wire logic [2:0] pc_in
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // select held low long enough for the two-flop sync to see it
  sequence s_hold; (!pc_host_o[2]) [*4] ##1 pc_host_o[2]; endsequence
  // read pair low at the device pins
  sequence s_rd; (pc_in == 3'b010) [*2]; endsequence
  property p_rst_pd; $fell(i_rst) |-> pd_dev_oe == 8'h00; endproperty
  property p_rst_pc; $fell(i_rst) |-> pc_dev_oe == 3'h0; endproperty
  property p_hold; $fell(pc_host_o[2]) |-> s_hold; endproperty
  // control bits are {cs_n, wr_n, rd_n}: a write pulls cs and wr low
  property p_wr_data; pc_host_o == 3'b001 |-> pd_host_oe == 8'hFF;
  endproperty
  property p_rd_rel; pc_host_o == 3'b010 |-> pd_host_oe == 8'h00;
  endproperty
  property p_rd_drv; s_rd |-> pd_dev_oe == 8'hFF; endproperty
  property p_wr_quiet; pc_in == 3'b001 |-> pd_dev_oe == 8'h00; endproperty
  property p_excl; pc_host_o[1:0] != 2'b00; endproperty
  a_rst_pd: assert property (p_rst_pd)
    else $error("data driver on after reset");
  a_rst_pc: assert property (p_rst_pc)
    else $error("control driver on after reset");
  a_hold: assert property (p_hold)
    else $error("select strobe length wrong");
  a_wr_data: assert property (p_wr_data)
    else $error("host not driving write data");
  a_rd_rel: assert property (p_rd_rel)
    else $error("host drives bus during read");
  a_rd_drv: assert property (p_rd_drv)
    else $error("device silent during read");
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("device drives bus during write");
  a_excl: assert property (p_excl)
    else $error("read and write strobes together");
endmodule

// [sim/dual_port_parallel_slave_test.sv]
`timescale 1ns/1ps
module dual_port_parallel_slave_test;
  localparam logic [2:0] ST = dps_pkg::REG_CTRL_DIR;
  logic       i_ref_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       h_wr = 1'b0;
  logic       h_rd = 1'b0;
  logic [7:0] h_wdata = 8'h00;
  logic       h_busy;
  logic [7:0] h_rdata;
  int         n_mismatch = 0;
  int         comparisons = 0;
  dps_if bus ();
  always #12.5 i_ref_clk = ~i_ref_clk;
  // pull-ups where nobody drives; the device wins a contended pin
  assign bus.pd_in = (bus.pd_dev_oe & bus.pd_dev_o)
    | (~bus.pd_dev_oe & ~(bus.pd_host_oe & ~bus.pd_host_o));
  assign bus.pc_in = (bus.pc_dev_oe & bus.pc_dev_o)
    | (~bus.pc_dev_oe & ~(bus.pc_host_oe & ~bus.pc_host_o));
  dps_device dps_device_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .pins(bus));
  dps_host dps_host_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_wr_req(h_wr), .i_rd_req(h_rd), .i_wdata(h_wdata), .o_busy(h_busy),
    .o_rd_valid(), .o_rdata(h_rdata), .pins(bus));
  dps_assertions dps_assertions_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .pd_dev_oe(bus.pd_dev_oe), .pd_host_oe(bus.pd_host_oe),
    .pc_dev_oe(bus.pc_dev_oe), .pc_host_o(bus.pc_host_o), .pc_in(bus.pc_in));
  task automatic conclude();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  // one host access, then room for the device sync to land
  task automatic host(input logic w, input logic [7:0] d);
    int n;
    @(posedge i_ref_clk);
    h_wr <= w;
    h_rd <= !w;
    h_wdata <= d;
    @(posedge i_ref_clk);
    h_wr <= 1'b0;
    h_rd <= 1'b0;
    #1;
    for (n = 0; n < 40 && h_busy !== 1'b0; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (n == 40) begin
      n_mismatch++;
      conclude();
    end
    repeat (4) @(posedge i_ref_clk);
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(dps_pkg::REG_DIR, 8'hFF);
    rd(ST, 8'h07);
    rd(3'h7, 8'h00);
    $display("test reset done");
    wr(dps_pkg::REG_LATCH, 8'hA5);
    wr(dps_pkg::REG_DIR, 8'h0F);
    rd(dps_pkg::REG_PINS, 8'hAF);
    check(bus.pd_dev_oe, 8'hF0);
    rd(dps_pkg::REG_LATCH, 8'hA5);
    wr(dps_pkg::REG_DIR, 8'hFF);
    wr(dps_pkg::REG_CLATCH, 8'h02);
    wr(ST, 8'h03);
    rd(dps_pkg::REG_CPINS, 8'h03);
    check({5'h00, bus.pc_dev_oe}, 8'h04);
    rd(dps_pkg::REG_CLATCH, 8'h02);
    wr(dps_pkg::REG_ANALOG, 8'h01);
    rd(dps_pkg::REG_CPINS, 8'h02);
    check({5'h00, bus.pc_dev_oe}, 8'h04);
    wr(dps_pkg::REG_ANALOG, 8'h00);
    wr(ST, 8'h17);
    rd(ST, 8'h17);
    $display("test gpio done");
    host(1'b1, 8'h3C);
    rd(ST, 8'h97);
    host(1'b1, 8'h5A);
    rd(ST, 8'hB7);
    rd(dps_pkg::REG_PINS, 8'h5A);
    rd(ST, 8'h37);
    wr(ST, 8'h17);
    rd(ST, 8'h17);
    wr(dps_pkg::REG_PINS, 8'hC3);
    rd(ST, 8'h57);
    host(1'b0, 8'h00);
    check(h_rdata, 8'hC3);
    rd(ST, 8'h17);
    $display("test slave done");
    conclude();
  end
endmodule
